// ==== core/cmp_event_ctrl.sv ====
// comparator event control: input selection, result sync, event flag and bus registers
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module cmp_event_ctrl
   import cmp_evt_pkg::*;
(
   input  wire logic                  CLK_SYS,
   input  wire logic                  SRST,
   // analog side
   input  wire logic                  COMP_RAW,
   input  wire logic                  CONVERTER_ENABLE,
   input  wire logic [2:0]            CHANNEL_SELECT,
   output var  cmp_evt_pkg::cmp_sel_s ANALOG_SEL,
   // processor side
   input  wire logic                  GLOBAL_IRQ_ENABLE,
   input  wire logic                  IRQ_VECTOR_ACK,
   output var  logic                  CMP_IRQ_REQ,
   output var  logic                  IRQ,
   // timer capture front end and converter auto trigger
   output var  logic                  CAPTURE_SELECT,
   output var  logic                  CAPTURE_INPUT,
   output var  logic [2:0]            AUTO_TRIGGER_SELECT,
   // control bus
   input  wire logic [7:0]            S_AXI_AWADDR,
   input  wire logic                  S_AXI_AWVALID,
   output var  logic                  S_AXI_AWREADY,
   input  wire logic [31:0]           S_AXI_WDATA,
   input  wire logic [3:0]            S_AXI_WSTRB,
   input  wire logic                  S_AXI_WVALID,
   output var  logic                  S_AXI_WREADY,
   output var  logic [1:0]            S_AXI_BRESP,
   output var  logic                  S_AXI_BVALID,
   input  wire logic                  S_AXI_BREADY,
   input  wire logic [7:0]            S_AXI_ARADDR,
   input  wire logic                  S_AXI_ARVALID,
   output var  logic                  S_AXI_ARREADY,
   output var  logic [31:0]           S_AXI_RDATA,
   output var  logic [1:0]            S_AXI_RRESP,
   output var  logic                  S_AXI_RVALID,
   input  wire logic                  S_AXI_RREADY
);
   // software visible state
   logic [7:0]        ctrl_ff;
   logic [7:0]        trig_ff;
   logic [STAT_W-1:0] stat_ff;
   logic [STAT_W-1:0] mask_ff;
   logic              flag_ff;

   // bus handshake state
   logic        awready_ff;
   logic        wready_ff;
   logic        aw_held_ff;
   logic        w_held_ff;
   logic [7:0]  waddr_ff;
   logic [7:0]  wdata_ff;
   logic        wstrb0_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;
   logic        arready_ff;
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;

   // output flops
   cmp_sel_s   sel_ff;
   logic       cmp_req_ff;
   logic       irq_ff;
   logic       cap_in_ff;
   logic       cap_sel_ff;

   // comparator result path
   logic        raw_gated;
   logic        result;
   logic        ev_toggle;
   logic        ev_match;
   event_mode_e mode;

   // analog selection: power-off holds result low
   assign raw_gated = COMP_RAW & ~ctrl_ff[BIT_POWER_OFF];

   level_sync #(
      .STAGES (SYNC_STAGES)
   ) u_sync (
      .CLK_SYS (CLK_SYS),
      .SRST    (SRST),
      .din     (raw_gated),
      .dout    (result)
   );

   assign mode = event_mode_e'(ctrl_ff[BIT_SEL_HI:BIT_SEL_LO]);

   edge_event u_edge (
      .CLK_SYS (CLK_SYS),
      .SRST    (SRST),
      .level   (result),
      .mode    (mode),
      .toggle  (ev_toggle),
      .match   (ev_match)
   );

   // bus handshakes and decode
   logic aw_hs;
   logic w_hs;
   logic do_write;
   logic ar_hs;
   logic nxt_aw_held;
   logic nxt_w_held;
   logic nxt_bvalid;
   logic nxt_rvalid;
   logic wr_ctrl;
   logic wr_trig;
   logic wr_mask;
   logic wr_hit;
   logic rd_hit;
   logic rd_stat;
   logic [31:0] rd_word;

   assign aw_hs       = S_AXI_AWVALID & awready_ff;
   assign w_hs        = S_AXI_WVALID & wready_ff;
   assign ar_hs       = S_AXI_ARVALID & arready_ff;
   assign do_write    = aw_held_ff & w_held_ff & ~bvalid_ff;
   assign nxt_aw_held = (aw_held_ff | aw_hs) & ~do_write;
   assign nxt_w_held  = (w_held_ff | w_hs) & ~do_write;
   assign nxt_bvalid  = do_write | (bvalid_ff & ~S_AXI_BREADY);
   assign nxt_rvalid  = ar_hs | (rvalid_ff & ~S_AXI_RREADY);

   assign wr_ctrl = do_write & wstrb0_ff & (waddr_ff == ADDR_CTRL_STATUS);
   assign wr_trig = do_write & wstrb0_ff & (waddr_ff == ADDR_TRIG_MUX);
   assign wr_mask = do_write & wstrb0_ff & (waddr_ff == ADDR_IRQ_MASK);
   assign wr_hit  = (waddr_ff == ADDR_CTRL_STATUS) || (waddr_ff == ADDR_TRIG_MUX) ||
                    (waddr_ff == ADDR_IRQ_STATUS)  || (waddr_ff == ADDR_IRQ_MASK);
   assign rd_stat = ar_hs & (S_AXI_ARADDR == ADDR_IRQ_STATUS);

   // read data selection
   logic [7:0] ctrl_view;
   assign ctrl_view = {ctrl_ff[7:6], result, flag_ff, ctrl_ff[3:0]};

   always_comb begin
      rd_hit  = 1'b1;
      rd_word = 32'h0000_0000;
      if (S_AXI_ARADDR == ADDR_CTRL_STATUS) begin
         rd_word = {24'h00_0000, ctrl_view};
      end else if (S_AXI_ARADDR == ADDR_TRIG_MUX) begin
         rd_word = {24'h00_0000, trig_ff};
      end else if (S_AXI_ARADDR == ADDR_IRQ_STATUS) begin
         rd_word = {30'h0000_0000, stat_ff};
      end else if (S_AXI_ARADDR == ADDR_IRQ_MASK) begin
         rd_word = {30'h0000_0000, mask_ff};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // event flag: set wins over vector ack and write-one clear
   logic flag_clr;
   logic nxt_flag;
   assign flag_clr = IRQ_VECTOR_ACK
                   | (wr_ctrl & wdata_ff[BIT_EVENT_FLAG]);
   assign nxt_flag = ev_match | (flag_ff & ~flag_clr);

   // sticky status: set wins over read clear
   logic [STAT_W-1:0] stat_set;
   logic [STAT_W-1:0] nxt_stat;
   assign stat_set = {ev_toggle, ev_match};
   assign nxt_stat = stat_set | (rd_stat ? STAT_RESET : stat_ff);

   // next values of the outputs
   cmp_sel_s nxt_sel;
   logic     nxt_cmp_req;
   logic     nxt_irq;
   logic     nxt_cap_in;
   logic     nxt_cap_sel;
   logic     mux_active;

   assign mux_active = trig_ff[BIT_NEG_MUX_EN] & ~CONVERTER_ENABLE;
   assign nxt_sel.power_off   = ctrl_ff[BIT_POWER_OFF];
   assign nxt_sel.pos_bandgap = ctrl_ff[BIT_BANDGAP_POS];
   assign nxt_sel.neg_use_mux = mux_active;
   assign nxt_sel.neg_channel = mux_active ? CHANNEL_SELECT : 3'h0;
   assign nxt_cmp_req = flag_ff & ctrl_ff[BIT_IRQ_ENABLE] & GLOBAL_IRQ_ENABLE;
   assign nxt_irq     = |(stat_ff & mask_ff);
   assign nxt_cap_in  = ctrl_ff[BIT_CAPTURE_ROUTE] & result;
   assign nxt_cap_sel = ~ctrl_ff[BIT_POWER_OFF] & ctrl_ff[BIT_CAPTURE_ROUTE];

   // control registers
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ctrl_ff <= CTRL_RESET;
         trig_ff <= TRIG_RESET;
         mask_ff <= STAT_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= wdata_ff;                  // result and flag bits unused here
         end
         if (wr_trig) begin
            trig_ff <= wdata_ff & 8'h47;          // only mux enable and trigger select
         end
         if (wr_mask) begin
            mask_ff <= wdata_ff[STAT_W-1:0];
         end
      end
   end

   // flags and status
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         flag_ff <= 1'b0;
         stat_ff <= STAT_RESET;
      end else begin
         flag_ff <= nxt_flag;
         stat_ff <= nxt_stat;
      end
   end

   // write channel
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
         waddr_ff   <= 8'h00;
         wdata_ff   <= 8'h00;
         wstrb0_ff  <= 1'b0;
      end else begin
         aw_held_ff <= nxt_aw_held;
         w_held_ff  <= nxt_w_held;
         awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
         wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
         bvalid_ff  <= nxt_bvalid;
         if (aw_hs) begin
            waddr_ff <= S_AXI_AWADDR;
         end
         if (w_hs) begin
            wdata_ff  <= S_AXI_WDATA[7:0];
            wstrb0_ff <= S_AXI_WSTRB[0];
         end
         if (do_write) begin
            bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // read channel
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= RESP_OKAY;
      end else begin
         arready_ff <= ~nxt_rvalid;
         rvalid_ff  <= nxt_rvalid;
         if (ar_hs) begin
            rdata_ff <= rd_word;
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // registered outputs
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         sel_ff     <= SEL_RESET;
         cmp_req_ff <= 1'b0;
         irq_ff     <= 1'b0;
         cap_in_ff  <= 1'b0;
         cap_sel_ff <= 1'b0;
      end else begin
         sel_ff     <= nxt_sel;
         cmp_req_ff <= nxt_cmp_req;
         irq_ff     <= nxt_irq;
         cap_in_ff  <= nxt_cap_in;
         cap_sel_ff <= nxt_cap_sel;
      end
   end

   // port hookup
   assign ANALOG_SEL          = sel_ff;
   assign CMP_IRQ_REQ         = cmp_req_ff;
   assign IRQ                 = irq_ff;
   assign CAPTURE_SELECT      = cap_sel_ff;
   assign CAPTURE_INPUT       = cap_in_ff;
   assign AUTO_TRIGGER_SELECT = trig_ff[BIT_TRIG_SEL_LSB +: TRIG_SEL_W];
   assign S_AXI_AWREADY       = awready_ff;
   assign S_AXI_WREADY        = wready_ff;
   assign S_AXI_BVALID        = bvalid_ff;
   assign S_AXI_BRESP         = bresp_ff;
   assign S_AXI_ARREADY       = arready_ff;
   assign S_AXI_RVALID        = rvalid_ff;
   assign S_AXI_RDATA         = rdata_ff;
   assign S_AXI_RRESP         = rresp_ff;
endmodule : cmp_event_ctrl
`default_nettype wire

// ==== core/cmp_evt_pkg.sv ====
// shared constants, register layout and carrier types of the comparator event block
package cmp_evt_pkg;

   // register byte addresses on the control bus
   localparam logic [7:0] ADDR_CTRL_STATUS  = 8'h00; // comparator_control_status
   localparam logic [7:0] ADDR_TRIG_MUX     = 8'h04; // converter_trigger_and_mux_control
   localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h08; // sticky events, cleared by read
   localparam logic [7:0] ADDR_IRQ_MASK     = 8'h0C; // enables for the sticky events

   // comparator_control_status field positions
   localparam int BIT_POWER_OFF     = 7;
   localparam int BIT_BANDGAP_POS   = 6;
   localparam int BIT_RESULT        = 5;
   localparam int BIT_EVENT_FLAG    = 4;
   localparam int BIT_IRQ_ENABLE    = 3;
   localparam int BIT_CAPTURE_ROUTE = 2;
   localparam int BIT_SEL_HI        = 1;
   localparam int BIT_SEL_LO        = 0;

   // converter_trigger_and_mux_control field positions
   localparam int BIT_NEG_MUX_EN    = 6;
   localparam int BIT_TRIG_SEL_LSB  = 0;
   localparam int TRIG_SEL_W        = 3;

   // sticky event status layout
   localparam int STAT_W            = 2;
   localparam int STAT_MATCH        = 0; // event matching the selected mode
   localparam int STAT_TOGGLE       = 1; // any change of the comparator result

   // values after reset
   localparam logic [7:0]        CTRL_RESET = 8'h00;
   localparam logic [7:0]        TRIG_RESET = 8'h00;
   localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // synchroniser depth of the comparator result
   localparam int SYNC_STAGES = 2;

   // flag-setting event modes
   typedef enum logic [1:0] {
      MODE_TOGGLE   = 2'h0,
      MODE_RESERVED = 2'h1,
      MODE_FALL     = 2'h2,
      MODE_RISE     = 2'h3
   } event_mode_e;

   // selection handed to the analog comparator and its input muxes
   typedef struct packed {
      logic       power_off;
      logic       pos_bandgap;
      logic       neg_use_mux;
      logic [2:0] neg_channel;
   } cmp_sel_s;

   localparam cmp_sel_s SEL_RESET = '{power_off: 1'b0, pos_bandgap: 1'b0,
                                      neg_use_mux: 1'b0, neg_channel: 3'h0};

endpackage : cmp_evt_pkg

// ==== core/edge_event.sv ====
// edge detector on the synchronised result with mode selection
`timescale 1ns/100ps
`default_nettype none
module edge_event
   import cmp_evt_pkg::*;
(
   input  wire logic                     CLK_SYS,
   input  wire logic                     SRST,
   input  wire logic                     level,
   input  wire cmp_evt_pkg::event_mode_e mode,
   output var  logic                     toggle,
   output var  logic                     match
);
   logic prev_ff;
   logic rise;
   logic fall;

   // remember last cycle's value
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= level;
      end
   end

   // compare with the previous cycle
   assign rise   = level & ~prev_ff;
   assign fall   = ~level & prev_ff;
   assign toggle = rise | fall;

   // mode select, reserved code raises nothing
   assign match = (mode == MODE_TOGGLE) ? toggle :
                  (mode == MODE_FALL)   ? fall   :
                  (mode == MODE_RISE)   ? rise   : 1'b0;
endmodule : edge_event
`default_nettype wire

// ==== core/level_sync.sv ====
// two-stage synchroniser for one level
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
   parameter int STAGES = 2
) (
   input  wire logic CLK_SYS,
   input  wire logic SRST,
   input  wire logic din,
   output var  logic dout
);
   logic [STAGES-1:0] chain_ff;

   // only the next stage, or dout for the last flop, reads each flop
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         chain_ff <= '0;
      end else begin
         chain_ff <= {chain_ff[STAGES-2:0], din};
      end
   end

   assign dout = chain_ff[STAGES-1];
endmodule : level_sync
`default_nettype wire

// ==== verif/analog_front_model.sv ====
// behavioural comparator and input muxes facing the block
`timescale 1ns/100ps
`default_nettype none
module analog_front_model
   import cmp_evt_pkg::*;
#(
   parameter int REF_MV  = 1100,
   parameter int STEP_MV = 400
) (
   input wire cmp_evt_pkg::cmp_sel_s sel,
   input var  int                    pos_mv,
   input var  int                    neg_mv,
   output var logic                  comp_raw
);
   int pos_in;
   int neg_in;
   // input muxes, then the decision; unpowered gives low
   assign pos_in = sel.pos_bandgap ? REF_MV : pos_mv;
   assign neg_in = sel.neg_use_mux ? STEP_MV * int'(sel.neg_channel) : neg_mv;
   assign comp_raw = sel.power_off ? 1'h0 : (pos_in > neg_in);
endmodule : analog_front_model
`default_nettype wire

// ==== verif/cmp_event_chk_assertions.sv ====
// port-level assertions of the comparator event block
`timescale 1ns/100ps
`default_nettype none
module cmp_event_chk
   import cmp_evt_pkg::*;
(
   input wire logic                  CLK_SYS,
   input wire logic                  SRST,
   input wire logic                  COMP_RAW,
   input wire logic                  CONVERTER_ENABLE,
   input wire logic [2:0]            CHANNEL_SELECT,
   input wire cmp_evt_pkg::cmp_sel_s ANALOG_SEL,
   input wire logic                  GLOBAL_IRQ_ENABLE,
   input wire logic                  CMP_IRQ_REQ,
   input wire logic                  CAPTURE_INPUT,
   input wire logic                  S_AXI_AWREADY,
   input wire logic                  S_AXI_WREADY,
   input wire logic                  S_AXI_BVALID,
   input wire logic                  S_AXI_BREADY,
   input wire logic [1:0]            S_AXI_BRESP,
   input wire logic                  S_AXI_ARVALID,
   input wire logic                  S_AXI_ARREADY,
   input wire logic                  S_AXI_RVALID,
   input wire logic                  S_AXI_RREADY,
   input wire logic [31:0]           S_AXI_RDATA
);
   default clocking dc @(posedge CLK_SYS);
   endclocking
   default disable iff (SRST);
   // interrupt, input selection, capture path and bus timing
   property p_req_gie;
      CMP_IRQ_REQ |-> $past(GLOBAL_IRQ_ENABLE);
   endproperty
   a_req_gie: assert property (p_req_gie)
      else $error("request without global enable");
   property p_neg_pin;
      !ANALOG_SEL.neg_use_mux |-> ANALOG_SEL.neg_channel == 3'h0;
   endproperty
   a_neg_pin: assert property (p_neg_pin)
      else $error("channel set while pin selected");
   property p_mux_conv;
      ANALOG_SEL.neg_use_mux |-> !$past(CONVERTER_ENABLE);
   endproperty
   a_mux_conv: assert property (p_mux_conv)
      else $error("mux used while converter on");
   property p_mux_chan;
      ANALOG_SEL.neg_use_mux |-> ANALOG_SEL.neg_channel == $past(CHANNEL_SELECT);
   endproperty
   a_mux_chan: assert property (p_mux_chan)
      else $error("wrong channel on negative input");
   property p_cap_raw;
      CAPTURE_INPUT |-> $past(COMP_RAW, 3);
   endproperty
   a_cap_raw: assert property (p_cap_raw)
      else $error("capture input without result");
   property p_r_lat;
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
   endproperty
   a_r_lat: assert property (p_r_lat)
      else $error("read answer late");
   property p_r_hold;
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read answer dropped");
   property p_b_hold;
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write answer dropped");
   property p_b_rise;
      $rose(S_AXI_BVALID) |-> !S_AXI_AWREADY && !S_AXI_WREADY;
   endproperty
   a_b_rise: assert property (p_b_rise)
      else $error("ready during write answer");
endmodule : cmp_event_chk
bind cmp_event_ctrl cmp_event_chk chk_u (.CLK_SYS(CLK_SYS), .SRST(SRST), .COMP_RAW(COMP_RAW),
   .CONVERTER_ENABLE(CONVERTER_ENABLE), .CHANNEL_SELECT(CHANNEL_SELECT), .ANALOG_SEL(ANALOG_SEL),
   .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .CMP_IRQ_REQ(CMP_IRQ_REQ), .CAPTURE_INPUT(CAPTURE_INPUT),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .S_AXI_RDATA(S_AXI_RDATA));
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench of the comparator event block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import cmp_evt_pkg::*;
   logic CLK_SYS = 1'h0, SRST = 1'h1, COMP_RAW, CONVERTER_ENABLE = 1'h0, GLOBAL_IRQ_ENABLE = 1'h0;
   logic IRQ_VECTOR_ACK = 1'h0, S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
   logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
   logic S_AXI_ARREADY, S_AXI_RVALID, CMP_IRQ_REQ, IRQ, CAPTURE_SELECT, CAPTURE_INPUT, f, lvl;
   logic [2:0]  CHANNEL_SELECT = 3'h0, AUTO_TRIGGER_SELECT;
   logic [3:0]  S_AXI_WSTRB = 4'hF;
   logic [7:0]  S_AXI_AWADDR = 8'h0, S_AXI_ARADDR = 8'h0;
   logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
   cmp_sel_s    ANALOG_SEL;
   int          pos_mv = 0, neg_mv = 1000, n_errors = 0, n_compared = 0, cyc = 0, seed = 32'hAD796416;
   always #25 CLK_SYS = ~CLK_SYS;
   analog_front_model model_u (.sel(ANALOG_SEL), .pos_mv(pos_mv), .neg_mv(neg_mv), .comp_raw(COMP_RAW));
   cmp_event_ctrl dut_u (.CLK_SYS(CLK_SYS), .SRST(SRST), .COMP_RAW(COMP_RAW), .CONVERTER_ENABLE(CONVERTER_ENABLE),
      .CHANNEL_SELECT(CHANNEL_SELECT), .ANALOG_SEL(ANALOG_SEL), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
      .IRQ_VECTOR_ACK(IRQ_VECTOR_ACK), .CMP_IRQ_REQ(CMP_IRQ_REQ), .IRQ(IRQ), .CAPTURE_SELECT(CAPTURE_SELECT),
      .CAPTURE_INPUT(CAPTURE_INPUT), .AUTO_TRIGGER_SELECT(AUTO_TRIGGER_SELECT), .S_AXI_AWADDR(S_AXI_AWADDR),
      .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
      .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
      .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
      .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
      .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
   // flag expected after one rise or fall in a given mode
   function automatic logic flag_exp(input int m, input logic rise);
      return (m == 0) || (m == 3 && rise) || (m == 2 && !rise);
   endfunction : flag_exp
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   // bus write: address and data together, answer taken after a random stall
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge CLK_SYS);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= {24'h0, d};
      S_AXI_AWVALID <= 1'h1;
      S_AXI_WVALID <= 1'h1;
      do begin
         @(posedge CLK_SYS);
         if (S_AXI_AWREADY)
            S_AXI_AWVALID <= 1'h0;
         if (S_AXI_WREADY)
            S_AXI_WVALID <= 1'h0;
      end while (S_AXI_AWVALID && !S_AXI_AWREADY || S_AXI_WVALID && !S_AXI_WREADY);
      repeat ($unsigned($random(seed)) % 3) @(posedge CLK_SYS);
      S_AXI_BREADY <= 1'h1;
      do @(posedge CLK_SYS); while (!(S_AXI_BVALID && S_AXI_BREADY));
      chk(32'(S_AXI_BRESP), 32'(er));
      S_AXI_BREADY <= 1'h0;
   endtask : wr
   // bus read with expected response and data
   task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
      @(posedge CLK_SYS);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'h1;
      do @(posedge CLK_SYS); while (!S_AXI_ARREADY);
      S_AXI_ARVALID <= 1'h0;
      repeat ($unsigned($random(seed)) % 3) @(posedge CLK_SYS);
      S_AXI_RREADY <= 1'h1;
      do @(posedge CLK_SYS); while (!(S_AXI_RVALID && S_AXI_RREADY));
      chk(32'(S_AXI_RRESP), 32'(er));
      chk(S_AXI_RDATA, ed);
      S_AXI_RREADY <= 1'h0;
   endtask : rd
   // random pin voltages on one side of the fixed negative level
   task automatic drive_cmp(input logic hi);
      @(posedge CLK_SYS);
      pos_mv <= hi ? 1500 + $unsigned($random(seed)) % 500 : $unsigned($random(seed)) % 900;
      repeat (4) @(posedge CLK_SYS);
      @(negedge CLK_SYS);
   endtask : drive_cmp
   always @(posedge CLK_SYS) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         finish_test();
      end
   end
   initial begin
      repeat (5) @(posedge CLK_SYS);
      SRST <= 1'h0;
      repeat (2) @(posedge CLK_SYS);
      rd(ADDR_CTRL_STATUS, RESP_OKAY, 32'h0);
      rd(ADDR_TRIG_MUX, RESP_OKAY, 32'h0);
      rd(8'h10, RESP_SLVERR, 32'h0);
      wr(8'h10, 8'hFF, RESP_SLVERR);
      // low byte lane off: the write is answered but ignored
      S_AXI_WSTRB <= 4'h0;
      wr(ADDR_TRIG_MUX, 8'h47, RESP_OKAY);
      S_AXI_WSTRB <= 4'hF;
      rd(ADDR_TRIG_MUX, RESP_OKAY, 32'h0);
      for (int i = 0; i < 4; i++) begin
         @(posedge CLK_SYS);
         CHANNEL_SELECT <= 3'($random(seed));
         CONVERTER_ENABLE <= i[0];
         wr(ADDR_TRIG_MUX, {1'h0, i[1], 6'h05}, RESP_OKAY);
         repeat (2) @(negedge CLK_SYS);
         chk(32'(ANALOG_SEL.neg_use_mux), 32'(i == 2));
         chk(32'(ANALOG_SEL.neg_channel), i == 2 ? 32'(CHANNEL_SELECT) : 32'h0);
         chk(32'(AUTO_TRIGGER_SELECT), 32'h5);
      end
      wr(ADDR_CTRL_STATUS, 8'hC4, RESP_OKAY);
      repeat (2) @(negedge CLK_SYS);
      chk(32'({ANALOG_SEL.power_off, ANALOG_SEL.pos_bandgap, CAPTURE_SELECT}), 32'h6);
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_IRQ_MASK, {6'h0, m[0], !m[0]}, RESP_OKAY);
         for (int e = 0; e < 2; e++) begin
            lvl = !e[0];
            f = flag_exp(m, lvl);
            wr(ADDR_CTRL_STATUS, {6'h05, m[1:0]}, RESP_OKAY);
            rd(ADDR_IRQ_STATUS, RESP_OKAY, 32'h0);
            drive_cmp(lvl);
            chk(32'(CAPTURE_INPUT), 32'(lvl));
            chk(32'(CAPTURE_SELECT), 32'h1);
            chk(32'(IRQ), 32'(m[0] | f));
            rd(ADDR_CTRL_STATUS, RESP_OKAY, 32'({2'h0, lvl, f, 2'h1, m[1:0]}));
            rd(ADDR_IRQ_STATUS, RESP_OKAY, 32'({1'h1, f}));
            repeat (2) @(negedge CLK_SYS);
            chk(32'(IRQ), 32'h0);
         end
      end
      @(posedge CLK_SYS);
      GLOBAL_IRQ_ENABLE <= 1'h1;
      wr(ADDR_CTRL_STATUS, 8'h1F, RESP_OKAY);
      drive_cmp(1'h1);
      chk(32'(CMP_IRQ_REQ), 32'h1);
      wr(ADDR_CTRL_STATUS, 8'h0F, RESP_OKAY);
      rd(ADDR_CTRL_STATUS, RESP_OKAY, 32'h3F);
      @(posedge CLK_SYS);
      GLOBAL_IRQ_ENABLE <= 1'h0;
      repeat (2) @(negedge CLK_SYS);
      chk(32'(CMP_IRQ_REQ), 32'h0);
      @(posedge CLK_SYS);
      IRQ_VECTOR_ACK <= 1'h1;
      @(posedge CLK_SYS);
      IRQ_VECTOR_ACK <= 1'h0;
      rd(ADDR_CTRL_STATUS, RESP_OKAY, 32'h2F);
      drive_cmp(1'h0);
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
